//--- hw/dps_pkg.sv
// ============================================================
// strobe phase-shift capture: shared constants and types
// ============================================================
// holds widths, counts and enumerations used by the capture logic.
// assumes a single 125 mhz system clock samples every link pin.
package dps_pkg;
  localparam int CLK_PERIOD_NS = 8; // system clock period, 125 mhz
  localparam int NUM_DQS = 10; // strobe pins per device edge
  localparam int DQ_PER_PIN = 8; // data bits owned by each strobe pin
  localparam int REF_PINS = 4; // reference clock pins per edge
  localparam int REF_SEL_W = 2;
  localparam int TAP_W = 4; // delay setting width, 16 taps
  localparam int PER_W = 8; // reference period measure width
  localparam int PHASE_W = 5; // phase code width
  localparam int PROD_W = PER_W + PHASE_W;
  localparam int PHASE_STEPS = 20; // one phase code step is 18 degrees
  localparam int LOCK_LIMIT = 256; // reference cycles allowed to lock
  localparam int CNT_W = 9;
  localparam int FIFO_DEPTH = 16;
  localparam int X8_BYTES = 1;
  localparam int X16_BYTES = 2;
  localparam int X32_BYTES = 4;
  localparam logic [TAP_W-1:0] TAP_RESET = 4'h0;
  localparam logic [PER_W-1:0] PER_STALL = 8'hff; // reference treated as stopped

  // data bits per strobe group
  typedef enum logic [1:0] {
    DPS_X8,
    DPS_X16,
    DPS_X32
  } dps_mode_t;

  // delay lock loop progress
  typedef enum logic [1:0] {
    DPS_WAIT,
    DPS_TRACK,
    DPS_LOCKED,
    DPS_FAIL
  } dps_state_t;
endpackage : dps_pkg

//--- hw/dps_capture.sv
// ============================================================
// strobe phase-shift capture: fifo, edge circuit and top
// ============================================================
// holds the capture fifo, one edge's reference loop with strobe
// delay and capture, and the top with top and bottom edge circuits.
// assumes every pin input is asynchronous to clk and is synchronised here.

// ============================================================
// capture fifo
// ============================================================
module dps_fifo #(
  parameter int WIDTH = 160,
  parameter int DEPTH = dps_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [CNT_W-1:0] count_r, count_nxt;
  logic do_wr, do_rd;

  // honest flags straight from the occupancy count
  assign in_ready = (count_r != CNT_W'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // pointer and count next values, wrap at depth
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (do_wr) begin
      wr_ptr_nxt = (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
    end
    if (do_rd) begin
      rd_ptr_nxt = (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
    end
    if (do_wr && !do_rd) begin
      count_nxt = count_r + 1'b1;
    end else if (do_rd && !do_wr) begin
      count_nxt = count_r - 1'b1;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  chk_fifo_bound: assert property (@(posedge clk) disable iff (!rst_b)
    count_r <= CNT_W'(DEPTH))
    else $error("fifo count above depth");
  chk_fifo_count: assert property (@(posedge clk) disable iff (!rst_b)
    do_wr && !do_rd |=> count_r == $past(count_r) + 1'b1)
    else $error("fifo count out of step");
endmodule : dps_fifo

// ============================================================
// one edge: reference loop, strobe delay, capture
// ============================================================
module dps_edge #(
  parameter int NUM_PINS = dps_pkg::NUM_DQS,
  parameter int DEPTH = dps_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [dps_pkg::REF_PINS-1:0] ref_pins,
  input wire logic [dps_pkg::REF_SEL_W-1:0] ref_sel,
  input wire logic [dps_pkg::PHASE_W-1:0] phase_code,
  input wire dps_pkg::dps_mode_t bus_mode,
  input wire logic side_mode,
  input wire logic [NUM_PINS-1:0] dqs,
  input wire logic [NUM_PINS*dps_pkg::DQ_PER_PIN-1:0] dq,
  output logic [dps_pkg::TAP_W-1:0] tap,
  output logic locked,
  output logic lock_fail,
  output logic cap_ready,
  output logic out_valid,
  input wire logic out_ready,
  output logic [2*NUM_PINS*dps_pkg::DQ_PER_PIN-1:0] out_data
);
  localparam int BW = dps_pkg::DQ_PER_PIN;
  localparam int DQ_W = NUM_PINS * BW;
  localparam int LINE = 2 ** dps_pkg::TAP_W;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // pin synchronisers, two flops each
  // ==========================================================
  logic [dps_pkg::REF_PINS-1:0] ref_m_r, ref_s_r;
  logic [NUM_PINS-1:0] dqs_m_r, dqs_s_r;
  logic [DQ_W-1:0] dq_m_r, dq_s_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_m_r <= '0;
      ref_s_r <= '0;
      dqs_m_r <= '0;
      dqs_s_r <= '0;
      dq_m_r <= '0;
      dq_s_r <= '0;
    end else begin
      ref_m_r <= ref_pins;
      ref_s_r <= ref_m_r;
      dqs_m_r <= dqs;
      dqs_s_r <= dqs_m_r;
      dq_m_r <= dq;
      dq_s_r <= dq_m_r;
    end
  end

  // ==========================================================
  // delay chains: reference copy plus one per strobe pin
  // ==========================================================
  logic ref_now, ref_prev_r, ref_dly, ref_dly_prev_r;
  logic [LINE-1:0] ref_line_r, ref_line_nxt;
  logic [LINE-1:0] dqs_line_r [NUM_PINS];
  logic [LINE-1:0] dqs_line_nxt [NUM_PINS];
  logic [NUM_PINS-1:0] dqs_dly, dqs_dly_prev_r;
  logic [dps_pkg::TAP_W-1:0] tap_r, tap_nxt;

  assign ref_now = ref_s_r[ref_sel];
  assign ref_dly = ref_line_r[tap_r];

  // every chain is read at the one shared tap setting
  always_comb begin
    ref_line_nxt = {ref_line_r[LINE-2:0], ref_now};
    for (int i = 0; i < NUM_PINS; i++) begin
      dqs_line_nxt[i] = {dqs_line_r[i][LINE-2:0], dqs_s_r[i]};
      dqs_dly[i] = dqs_line_r[i][tap_r];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_line_r <= '0;
      ref_prev_r <= 1'b0;
      ref_dly_prev_r <= 1'b0;
      dqs_dly_prev_r <= '0;
      for (int i = 0; i < NUM_PINS; i++) begin
        dqs_line_r[i] <= '0;
      end
    end else begin
      ref_line_r <= ref_line_nxt;
      ref_prev_r <= ref_now;
      ref_dly_prev_r <= ref_dly;
      dqs_dly_prev_r <= dqs_dly;
      for (int i = 0; i < NUM_PINS; i++) begin
        dqs_line_r[i] <= dqs_line_nxt[i];
      end
    end
  end

  // ==========================================================
  // phase comparator, up/down counter and lock state
  // ==========================================================
  logic ref_rise, ref_fall, dref_rise, hit, step_up, step_dn;
  logic [dps_pkg::PER_W-1:0] since_r, since_nxt, period_r, period_nxt;
  logic [dps_pkg::PROD_W-1:0] prod, target;
  logic [dps_pkg::CNT_W-1:0] ref_cnt_r, ref_cnt_nxt;
  dps_pkg::dps_state_t state_r, state_nxt;

  assign ref_rise = ref_now && !ref_prev_r;
  assign ref_fall = !ref_now && ref_prev_r;
  assign dref_rise = ref_dly && !ref_dly_prev_r;
  // wanted delay is the chosen fraction of the measured period
  assign prod = period_r * phase_code;
  assign target = prod / dps_pkg::PROD_W'(dps_pkg::PHASE_STEPS);
  assign step_up = dref_rise && (dps_pkg::PROD_W'(since_r) < target);
  assign step_dn = dref_rise && (dps_pkg::PROD_W'(since_r) > target);
  assign hit = dref_rise && (dps_pkg::PROD_W'(since_r) == target);

  // a stopped reference drops a tracking or locked loop back to waiting
  always_comb begin
    since_nxt = since_r;
    period_nxt = period_r;
    tap_nxt = tap_r;
    ref_cnt_nxt = ref_cnt_r;
    state_nxt = state_r;
    if (ref_rise) begin
      since_nxt = '0;
      period_nxt = since_r + 1'b1;
    end else if (since_r != dps_pkg::PER_STALL) begin
      since_nxt = since_r + 1'b1;
    end
    if (state_r != dps_pkg::DPS_WAIT && state_r != dps_pkg::DPS_FAIL) begin
      if (step_up && tap_r != '1) begin
        tap_nxt = tap_r + 1'b1;
      end else if (step_dn && tap_r != '0) begin
        tap_nxt = tap_r - 1'b1;
      end
    end
    case (state_r)
      dps_pkg::DPS_WAIT: begin
        ref_cnt_nxt = '0;
        // first rise after a stall only starts the period measure;
        // tracking on it would lock to a zero-length period
        if (ref_rise && since_r != dps_pkg::PER_STALL) begin
          state_nxt = dps_pkg::DPS_TRACK;
        end
      end
      dps_pkg::DPS_TRACK: begin
        if (ref_rise) begin
          ref_cnt_nxt = ref_cnt_r + 1'b1;
        end
        if (hit) begin
          state_nxt = dps_pkg::DPS_LOCKED;
        end else if (ref_cnt_r == dps_pkg::CNT_W'(dps_pkg::LOCK_LIMIT)) begin
          state_nxt = dps_pkg::DPS_FAIL;
        end else if (since_r == dps_pkg::PER_STALL) begin
          state_nxt = dps_pkg::DPS_WAIT;
        end
      end
      dps_pkg::DPS_LOCKED: begin
        // keeps tracking drift while locked
        if (since_r == dps_pkg::PER_STALL) begin
          state_nxt = dps_pkg::DPS_WAIT;
        end
      end
      dps_pkg::DPS_FAIL: state_nxt = dps_pkg::DPS_FAIL;
      default: state_nxt = dps_pkg::DPS_WAIT;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      since_r <= dps_pkg::PER_STALL;
      period_r <= '0;
      tap_r <= dps_pkg::TAP_RESET;
      ref_cnt_r <= '0;
      state_r <= dps_pkg::DPS_WAIT;
    end else begin
      since_r <= since_nxt;
      period_r <= period_nxt;
      tap_r <= tap_nxt;
      ref_cnt_r <= ref_cnt_nxt;
      state_r <= state_nxt;
    end
  end

  assign tap = tap_r;
  assign locked = (state_r == dps_pkg::DPS_LOCKED);
  assign lock_fail = (state_r == dps_pkg::DPS_FAIL);

  // ==========================================================
  // data capture: rise and fall registers per byte
  // ==========================================================
  logic [NUM_PINS-1:0] pin_rise, pin_fall;
  logic [DQ_W-1:0] rise_r, rise_nxt, fall_r, fall_nxt;
  logic push;
  int grp;

  // side banks ignore the strobe and use the undelayed reference
  always_comb begin
    pin_rise = side_mode ? {NUM_PINS{ref_rise}} : (dqs_dly & ~dqs_dly_prev_r);
    pin_fall = side_mode ? {NUM_PINS{ref_fall}} : (~dqs_dly & dqs_dly_prev_r);
    case (bus_mode)
      dps_pkg::DPS_X16: grp = dps_pkg::X16_BYTES;
      dps_pkg::DPS_X32: grp = dps_pkg::X32_BYTES;
      default: grp = dps_pkg::X8_BYTES;
    endcase
    rise_nxt = rise_r;
    fall_nxt = fall_r;
    // each byte is clocked by the lead strobe of its group
    for (int b = 0; b < NUM_PINS; b++) begin
      if (pin_rise[(b / grp) * grp]) begin
        rise_nxt[b*BW +: BW] = dq_s_r[b*BW +: BW];
      end
      if (pin_fall[(b / grp) * grp]) begin
        fall_nxt[b*BW +: BW] = dq_s_r[b*BW +: BW];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_r <= '0;
      fall_r <= '0;
    end else begin
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  // a beat pair completes on the lead strobe's falling edge
  assign push = pin_fall[0];

  // pins cannot be stalled; a full fifo drops the pair, seen on cap_ready
  dps_fifo #(
    .WIDTH(2 * DQ_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(push),
    .in_ready(cap_ready),
    .in_data({fall_nxt, rise_r}),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_data)
  );

  // ==========================================================
  // checks
  // ==========================================================
  sequence s_locking;
    state_r == dps_pkg::DPS_TRACK ##1 state_r == dps_pkg::DPS_LOCKED;
  endsequence

  chk_tap_step: assert property (
    tap_r == $past(tap_r) || tap_r == $past(tap_r) + 1'b1 || tap_r == $past(tap_r) - 1'b1)
    else $error("tap moved more than one step");
  chk_up_step: assert property (
    step_up && tap_r != '1 && state_r == dps_pkg::DPS_TRACK |=> tap_r == $past(tap_r) + 1'b1)
    else $error("tap missed an up step");
  chk_lock_bound: assert property (
    state_r == dps_pkg::DPS_TRACK |-> ref_cnt_r <= dps_pkg::CNT_W'(dps_pkg::LOCK_LIMIT))
    else $error("tracking ran past lock limit");
  chk_lock_cause: assert property (
    s_locking |-> $past(hit))
    else $error("lock without comparator hit");
  chk_fail_sticky: assert property (
    lock_fail |=> lock_fail)
    else $error("lock failure cleared itself");
  chk_side_ignore: assert property (
    side_mode |-> push == ref_fall)
    else $error("side capture not on reference");
  chk_strobe_push: assert property (
    !side_mode && push |-> !dqs_dly[0] && dqs_dly_prev_r[0])
    else $error("push without delayed strobe fall");
  chk_zero_delay: assert property (
    tap_r == '0 && $past(tap_r) == '0 |-> dqs_dly[0] == $past(dqs_s_r[0]))
    else $error("delay chain tap zero wrong");
endmodule : dps_edge

// ============================================================
// top: two independent edge circuits, banks 3/4 and 7/8
// ============================================================
module dps_capture #(
  parameter int NUM_PINS = dps_pkg::NUM_DQS,
  parameter int DEPTH = dps_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [dps_pkg::REF_PINS-1:0] ref_clk_top,
  input wire logic [dps_pkg::REF_PINS-1:0] ref_clk_bot,
  input wire logic [dps_pkg::REF_SEL_W-1:0] ref_sel_top,
  input wire logic [dps_pkg::REF_SEL_W-1:0] ref_sel_bot,
  input wire logic [dps_pkg::PHASE_W-1:0] phase_top,
  input wire logic [dps_pkg::PHASE_W-1:0] phase_bot,
  input wire dps_pkg::dps_mode_t bus_mode,
  input wire logic side_mode,
  input wire logic [NUM_PINS-1:0] dqs_top,
  input wire logic [NUM_PINS*dps_pkg::DQ_PER_PIN-1:0] dq_top,
  input wire logic [NUM_PINS-1:0] dqs_bot,
  input wire logic [NUM_PINS*dps_pkg::DQ_PER_PIN-1:0] dq_bot,
  output logic [dps_pkg::TAP_W-1:0] tap_top,
  output logic [dps_pkg::TAP_W-1:0] tap_bot,
  output logic locked_top,
  output logic locked_bot,
  output logic lock_fail_top,
  output logic lock_fail_bot,
  output logic cap_ready_top,
  output logic cap_ready_bot,
  output logic out_valid_top,
  input wire logic out_ready_top,
  output logic [2*NUM_PINS*dps_pkg::DQ_PER_PIN-1:0] out_data_top,
  output logic out_valid_bot,
  input wire logic out_ready_bot,
  output logic [2*NUM_PINS*dps_pkg::DQ_PER_PIN-1:0] out_data_bot
);
  // top edge: reference pins 15..12, banks 3 and 4
  dps_edge #(.NUM_PINS(NUM_PINS), .DEPTH(DEPTH)) u_top (
    .clk(clk), .rst_b(rst_b), .ref_pins(ref_clk_top), .ref_sel(ref_sel_top),
    .phase_code(phase_top), .bus_mode(bus_mode), .side_mode(side_mode),
    .dqs(dqs_top), .dq(dq_top), .tap(tap_top), .locked(locked_top),
    .lock_fail(lock_fail_top), .cap_ready(cap_ready_top), .out_valid(out_valid_top),
    .out_ready(out_ready_top), .out_data(out_data_top)
  );

  // bottom edge: reference pins 7..4, banks 7 and 8, own phase
  dps_edge #(.NUM_PINS(NUM_PINS), .DEPTH(DEPTH)) u_bot (
    .clk(clk), .rst_b(rst_b), .ref_pins(ref_clk_bot), .ref_sel(ref_sel_bot),
    .phase_code(phase_bot), .bus_mode(bus_mode), .side_mode(side_mode),
    .dqs(dqs_bot), .dq(dq_bot), .tap(tap_bot), .locked(locked_bot),
    .lock_fail(lock_fail_bot), .cap_ready(cap_ready_bot), .out_valid(out_valid_bot),
    .out_ready(out_ready_bot), .out_data(out_data_bot)
  );
endmodule : dps_capture

//--- verification/dps_mem_model.sv
// ============================================================
// far side: memory device and system reference clock source
// ============================================================
// holds a behavioural memory that returns read bursts with
// edge-aligned strobes, plus the free-running reference clock.
// assumes the bench calls burst() away from the clk rising edge.
module dps_mem_model (
  input wire logic ref_en,
  output logic [3:0] ref_clk_top,
  output logic [3:0] ref_clk_bot,
  output logic [9:0] dqs_top,
  output logic [79:0] dq_top,
  output logic [9:0] dqs_bot,
  output logic [79:0] dq_bot
);
  timeunit 1ns;
  timeprecision 1ps;

  // ============================================================
  // reference clock
  // ============================================================
  // 64 ns period equals the strobe period; odd start offset keeps
  // it unrelated in phase to clk
  logic ref_r = 1'b0;
  initial begin
    #3;
    forever #32 ref_r = ~ref_r;
  end

  // fixed pins: top drives its pin 15, bottom its pin 4, others idle
  assign ref_clk_top = ref_en ? {ref_r, 3'h0} : 4'h0;
  assign ref_clk_bot = ref_en ? {3'h0, ref_r} : 4'h0;

  // ============================================================
  // read burst
  // ============================================================
  // strobe stands still outside frames; released data shows the
  // inverse of its last value so stale data never looks valid
  initial begin
    dqs_top = 10'h000;
    dqs_bot = 10'h000;
    dq_top = 80'h0;
    dq_bot = 80'h0;
  end

  // one beat pair: edge-aligned data, strobes only on masked pins
  task automatic burst(input logic [9:0] mask, input logic [79:0] r, input logic [79:0] f);
    dq_top = r;
    dq_bot = r;
    dqs_top = mask;
    dqs_bot = mask;
    #32;
    dq_top = f;
    dq_bot = f;
    dqs_top = 10'h000;
    dqs_bot = 10'h000;
    #32;
    dq_top = ~f;
    dq_bot = ~f;
  endtask : burst
endmodule : dps_mem_model

//--- verification/tb_dps_capture.sv
// ============================================================
// testbench for the strobe phase-shift capture top
// ============================================================
// drives both edges through the memory model and judges lock,
// tap values, capture words, fifo fill and reference loss.
// assumes a reference on top pin 15 and bottom pin 4 only.
module tb_dps_capture;
  timeunit 1ns;
  timeprecision 1ps;

  // ============================================================
  // stimulus and wiring
  // ============================================================
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ref_en = 1'b0;
  logic [1:0] sel_top = 2'h3;
  logic [1:0] sel_bot = 2'h0;
  logic [4:0] phase_top = 5'h05;
  logic [4:0] phase_bot = 5'h04;
  dps_pkg::dps_mode_t bus_mode = dps_pkg::DPS_X8;
  logic side_mode = 1'b0;
  logic rdy_top = 1'b0;
  logic rdy_bot = 1'b0;
  logic [3:0] ref_clk_top, ref_clk_bot, tap_top, tap_bot;
  logic [9:0] dqs_top, dqs_bot;
  logic [79:0] dq_top, dq_bot;
  logic locked_top, locked_bot, lock_fail_top, lock_fail_bot;
  logic cap_ready_top, cap_ready_bot, out_valid_top, out_valid_bot;
  logic [159:0] out_data_top, out_data_bot;
  int fails = 0;
  int comparisons = 0;

  // 125 mhz system clock
  always #4 clk = ~clk;

  dps_mem_model u_mem (.ref_en(ref_en), .ref_clk_top(ref_clk_top),
    .ref_clk_bot(ref_clk_bot), .dqs_top(dqs_top), .dq_top(dq_top),
    .dqs_bot(dqs_bot), .dq_bot(dq_bot));

  dps_capture u_dut (.clk(clk), .rst_b(rst_b), .ref_clk_top(ref_clk_top),
    .ref_clk_bot(ref_clk_bot), .ref_sel_top(sel_top), .ref_sel_bot(sel_bot),
    .phase_top(phase_top), .phase_bot(phase_bot), .bus_mode(bus_mode),
    .side_mode(side_mode), .dqs_top(dqs_top), .dq_top(dq_top), .dqs_bot(dqs_bot),
    .dq_bot(dq_bot), .tap_top(tap_top), .tap_bot(tap_bot), .locked_top(locked_top),
    .locked_bot(locked_bot), .lock_fail_top(lock_fail_top),
    .lock_fail_bot(lock_fail_bot), .cap_ready_top(cap_ready_top),
    .cap_ready_bot(cap_ready_bot), .out_valid_top(out_valid_top),
    .out_ready_top(rdy_top), .out_data_top(out_data_top),
    .out_valid_bot(out_valid_bot), .out_ready_bot(rdy_bot),
    .out_data_bot(out_data_bot));

  // ============================================================
  // checking and closing
  // ============================================================
  task automatic chk(input string what, input logic [159:0] exp, input logic [159:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ============================================================
  // scenarios
  // ============================================================
  // both loops lock, each to its own phase: 8 clk period, 90 and 72 deg
  task automatic t_lock;
    int i;
    for (i = 0; i < 2200 && !(locked_top === 1'b1 && locked_bot === 1'b1); i++) begin
      @(negedge clk);
    end
    chk("locked_top", 1, locked_top);
    chk("locked_bot", 1, locked_bot);
    chk("lock_fail_top", 0, lock_fail_top);
    chk("lock_fail_bot", 0, lock_fail_bot);
    chk("tap_top", 2, tap_top);
    chk("tap_bot", 1, tap_bot);
  endtask : t_lock

  // one burst per group width; only lead strobes move, the rest stand still
  task automatic t_capture(input dps_pkg::dps_mode_t m, input logic [9:0] mask);
    logic [79:0] r;
    logic [79:0] f;
    int i;
    r = 80'h0123_4567_89ab_cdef_1357 + 80'(m);
    f = {r[39:0], r[79:40]};
    bus_mode = m;
    u_mem.burst(mask, r, f);
    for (i = 0; i < 20 && out_valid_top !== 1'b1; i++) begin
      @(negedge clk);
    end
    @(negedge clk);
    chk("out_data_top", {f, r}, out_data_top);
    chk("out_data_bot", {f, r}, out_data_bot);
    rdy_top = 1'b1;
    rdy_bot = 1'b1;
    @(negedge clk);
    rdy_top = 1'b0;
    rdy_bot = 1'b0;
    chk("out_valid_top", 0, out_valid_top);
    chk("out_valid_bot", 0, out_valid_bot);
  endtask : t_capture

  // side-bank mode captures on reference edges with strobes idle,
  // so a stalled consumer lets the fifo fill until it refuses
  task automatic t_fill;
    int i;
    int n_t;
    int n_b;
    n_t = 0;
    n_b = 0;
    side_mode = 1'b1;
    for (i = 0; i < 400 && !(cap_ready_top === 1'b0 && cap_ready_bot === 1'b0); i++) begin
      @(negedge clk);
    end
    chk("cap_ready_top", 0, cap_ready_top);
    chk("cap_ready_bot", 0, cap_ready_bot);
    side_mode = 1'b0;
    repeat (8) @(negedge clk);
    rdy_top = 1'b1;
    rdy_bot = 1'b1;
    repeat (40) begin
      n_t += int'(out_valid_top === 1'b1);
      n_b += int'(out_valid_bot === 1'b1);
      @(negedge clk);
    end
    rdy_top = 1'b0;
    rdy_bot = 1'b0;
    chk("drained_top", dps_pkg::FIFO_DEPTH, n_t);
    chk("drained_bot", dps_pkg::FIFO_DEPTH, n_b);
    chk("cap_ready_top", 1, cap_ready_top);
  endtask : t_fill

  // selecting a dead pin drops top lock only; reselecting relocks
  task automatic t_stop;
    int i;
    sel_top = 2'h1;
    for (i = 0; i < 300 && locked_top !== 1'b0; i++) begin
      @(negedge clk);
    end
    chk("locked_top", 0, locked_top);
    chk("locked_bot", 1, locked_bot);
    sel_top = 2'h3;
    for (i = 0; i < 2200 && locked_top !== 1'b1; i++) begin
      @(negedge clk);
    end
    chk("locked_top", 1, locked_top);
    chk("tap_top", 2, tap_top);
  endtask : t_stop

  // mid-run reset, then a full-period phase the taps cannot reach:
  // bottom runs out of counted rises and fails, top relocks alone
  task automatic t_fail;
    int i;
    rst_b = 1'b0;
    phase_bot = 5'h14;
    repeat (2) @(negedge clk);
    chk("tap_top", 4'h0, tap_top);
    chk("locked_top", 1'b0, locked_top);
    chk("cap_ready_top", 1'b1, cap_ready_top);
    chk("out_valid_top", 1'b0, out_valid_top);
    rst_b = 1'b1;
    for (i = 0; i < 2400 && lock_fail_bot !== 1'b1; i++) begin
      @(negedge clk);
    end
    chk("lock_fail_bot", 1'b1, lock_fail_bot);
    chk("locked_bot", 1'b0, locked_bot);
    chk("tap_bot", 4'hf, tap_bot);
    chk("locked_top", 1'b1, locked_top);
    chk("tap_top", 4'h2, tap_top);
  endtask : t_fail

  // ============================================================
  // main sequence and watchdog
  // ============================================================
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    ref_en = 1'b1;
    t_lock();
    t_capture(dps_pkg::DPS_X8, 10'h3ff);
    t_capture(dps_pkg::DPS_X16, 10'h155);
    t_capture(dps_pkg::DPS_X32, 10'h111);
    t_fill();
    t_stop();
    t_fail();
    tally_and_finish();
  end

  // roughly four and a half times the expected run length
  initial begin
    #96000;
    fails++;
    $display("[ERR] watchdog expected done seen hang");
    tally_and_finish();
  end
endmodule : tb_dps_capture
